// [design/aosc_output_stage.sv]
// aosc_output_stage: output side of a pipelined sampling converter.
// expects raw offset-binary samples on the sample clock; pins come
// from outside and are synchronised; serial-port bits are core-clock.
`timescale 1ns/100ps

// How it works
// - power-down pin high: power down, outputs tri-stated
// - power-down released: resume after a wake-up delay scaled to the drained charge
// - wake-up delay scales with time spent down, up to full discharge
// - serial-controlled standby keeps reference, wakes faster
// - strap mode: format pin picks binary or twos
// - serial mode also offers gray code output
// - range flag shares the data word's latency
// - flag low in range, high beyond range
// - flag holds until an in-range conversion completes or the converter stops
// - output enable low drives, high tri-states
// - word appears twelve sample cycles after sampling
// - words launch on the sample clock rising edge
// - data clock out; receiver captures on rising edge
// - fourteen-bit parallel output word
// - offset binary codes; twos inverts the msb
// - beyond range clamps to full-scale code
module aosc_output_stage
  import aosc_pkg::*;
#(
  parameter int DATA_W = AOSC_DATA_W,
  parameter int LATENCY = AOSC_LATENCY,
  parameter int DISCH_CYCLES = AOSC_DISCH_CYCLES,
  parameter int WAKE_CYCLES = AOSC_WAKE_CYCLES,
  parameter int STBY_WAKE_CYCLES = AOSC_STBY_WAKE_CYCLES
)
(
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_core_ce,
  input wire logic i_power_down_pin,
  input wire logic i_output_enable_n,
  input wire logic i_format_select_pin,
  input wire logic i_serial_select_n,
  input wire aosc_fmt_type i_serial_format,
  input wire logic i_serial_power_down,
  input wire logic i_serial_standby,
  input wire logic i_sample_clk,
  input wire aosc_sample_type i_sample,
  output logic [DATA_W-1:0] o_data,
  output logic o_data_oe,
  output logic o_out_of_range,
  output logic o_out_of_range_oe,
  output logic o_data_clock_out,
  output logic o_converting
);

  // elaboration-time checks on the parameters
  generate
    if (DATA_W != AOSC_DATA_W)
    begin : g_bad_width
      $error("aosc_output_stage: data width must match package");
    end
    if (LATENCY < 2)
    begin : g_bad_latency
      $error("aosc_output_stage: latency must be at least 2");
    end
    if (DISCH_CYCLES < 1 || WAKE_CYCLES < 1 || STBY_WAKE_CYCLES < 1)
    begin : g_bad_counts
      $error("aosc_output_stage: timing counts must be positive");
    end
    if (WAKE_CYCLES >= (1 << AOSC_CNT_W) ||
        DISCH_CYCLES >= (1 << AOSC_CNT_W))
    begin : g_bad_range
      $error("aosc_output_stage: timing counts exceed counter width");
    end
  endgenerate

  // power sequencing states
  typedef enum logic [1:0]
  {
    ST_RUN,
    ST_DOWN,
    ST_STBY,
    ST_WAKE
  } aosc_pwr_type;

  // counter constants at counter width
  localparam logic [AOSC_CNT_W-1:0] DISCH_MAX = AOSC_CNT_W'(DISCH_CYCLES);
  localparam logic [AOSC_CNT_W-1:0] STBY_LOAD =
    AOSC_CNT_W'(STBY_WAKE_CYCLES);
  localparam int PROD_W = 2 * AOSC_CNT_W;

  // core domain: pin synchronisers, two stages each
  logic [3:0] pin_meta_q; // first stage, read only by second stage
  logic [3:0] pin_sync_q; // second stage, safe to use
  // core domain: power state and timing
  aosc_pwr_type pwr_q;
  aosc_pwr_type pwr_d;
  logic [AOSC_CNT_W-1:0] disch_q; // how far the reference has drained
  logic [AOSC_CNT_W-1:0] disch_d;
  logic [AOSC_CNT_W-1:0] wake_q; // remaining wake-up cycles
  logic [AOSC_CNT_W-1:0] wake_d;
  logic [PROD_W-1:0] wake_prod; // scaled wake-up length
  logic [AOSC_CNT_W-1:0] wake_load;
  // core domain: decoded controls
  logic pd_pin;
  logic oe_n_pin;
  logic fmt_pin;
  logic strap_mode;
  logic pd_req;
  logic stby_req;
  aosc_fmt_type fmt_sel;
  aosc_fmt_type fmt_q; // registered format, crosses to sample domain
  logic run_q; // converter running, crosses to sample domain
  logic drive_q; // output drivers enabled

  // sample domain: synchronised controls and pipeline
  logic run_meta_q;
  logic run_s_q;
  logic [1:0] fmt_meta_q;
  logic [1:0] fmt_s_q;
  logic [1:0] fmt_prev_q; // last synced format, for the agreement test
  logic [1:0] fmt_use_q; // format applied to outgoing words
  aosc_stage_type pipe_q [LATENCY-1];
  aosc_stage_type stage_in;
  logic [DATA_W-1:0] fmt_word;
  logic [DATA_W-1:0] data_q;
  logic oor_q;

  // core domain: external pins pass two flops before any logic
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      pin_meta_q <= 4'h0;
      pin_sync_q <= 4'h0;
    end
    else if (i_core_ce)
    begin
      pin_meta_q <= {i_serial_select_n, i_format_select_pin,
                     i_output_enable_n, i_power_down_pin};
      pin_sync_q <= pin_meta_q;
    end
  end

  // decoded pin levels
  assign pd_pin = pin_sync_q[0];
  assign oe_n_pin = pin_sync_q[1];
  assign fmt_pin = pin_sync_q[2];
  assign strap_mode = pin_sync_q[3];

  // power-down from the pin always; serial sources only in serial mode
  assign pd_req = pd_pin | (!strap_mode & i_serial_power_down);
  assign stby_req = !strap_mode & i_serial_standby & !pd_req;

  // format choice: strap pin or serial selection
  always_comb
  begin
    if (strap_mode)
    begin
      // static pin level picks binary or twos complement
      fmt_sel = fmt_pin ? AOSC_FMT_TWOS : AOSC_FMT_BINARY;
    end
    else if (i_serial_format == AOSC_FMT_GRAY)
    begin
      fmt_sel = AOSC_FMT_GRAY;
    end
    else if (i_serial_format == AOSC_FMT_TWOS)
    begin
      fmt_sel = AOSC_FMT_TWOS;
    end
    else
    begin
      // unused code falls back to binary
      fmt_sel = AOSC_FMT_BINARY;
    end
  end

  // wake-up length in proportion to the drained charge
  assign wake_prod = PROD_W'(disch_q) * PROD_W'(WAKE_CYCLES)
                     / PROD_W'(DISCH_CYCLES);
  assign wake_load = (wake_prod == '0) ? AOSC_CNT_W'(1)
                     : wake_prod[AOSC_CNT_W-1:0];

  // power state sequencing
  always_comb
  begin
    pwr_d = pwr_q;
    disch_d = disch_q;
    wake_d = wake_q;
    case (pwr_q)
      ST_RUN:
      begin
        // reference fully charged while running
        disch_d = '0;
        if (pd_req)
        begin
          pwr_d = ST_DOWN;
        end
        else if (stby_req)
        begin
          pwr_d = ST_STBY;
        end
      end
      ST_DOWN:
      begin
        // reference drains until fully discharged
        if (disch_q < DISCH_MAX)
        begin
          disch_d = disch_q + AOSC_CNT_W'(1);
        end
        if (!pd_req)
        begin
          pwr_d = ST_WAKE;
          wake_d = wake_load;
        end
      end
      ST_STBY:
      begin
        // reference kept up, so only a short wake-up
        if (pd_req)
        begin
          pwr_d = ST_DOWN;
        end
        else if (!stby_req)
        begin
          pwr_d = ST_WAKE;
          wake_d = STBY_LOAD;
        end
      end
      ST_WAKE:
      begin
        // recharge; drained level is held until the run state clears it
        if (pd_req)
        begin
          pwr_d = ST_DOWN;
        end
        else if (wake_q <= AOSC_CNT_W'(1))
        begin
          pwr_d = ST_RUN;
          wake_d = '0;
        end
        else
        begin
          wake_d = wake_q - AOSC_CNT_W'(1);
        end
      end
      default:
      begin
        pwr_d = ST_RUN;
      end
    endcase
  end

  // power state registers
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      pwr_q <= ST_RUN;
      disch_q <= '0;
      wake_q <= '0;
    end
    else if (i_core_ce)
    begin
      pwr_q <= pwr_d;
      disch_q <= disch_d;
      wake_q <= wake_d;
    end
  end

  // run level and format held for the sample domain; driver enable for the pins
  always_ff @(posedge i_core_clk)
  begin
    if (!i_reset_n)
    begin
      run_q <= 1'b0;
      drive_q <= 1'b0;
      fmt_q <= AOSC_FMT_BINARY;
    end
    else if (i_core_ce)
    begin
      run_q <= (pwr_d == ST_RUN);
      // drivers on only when not powered down or in standby and enable is low
      drive_q <= !pd_req && (pwr_d != ST_STBY) && !oe_n_pin;
      fmt_q <= fmt_sel;
    end
  end

  // three-state enables for data and flag
  assign o_data_oe = drive_q;
  assign o_out_of_range_oe = drive_q;
  assign o_converting = run_q;

  // sample domain: level crossings for run and format
  always_ff @(posedge i_sample_clk)
  begin
    run_meta_q <= run_q;
    run_s_q <= run_meta_q;
    fmt_meta_q <= fmt_q;
    fmt_s_q <= fmt_meta_q;
    // two bits may settle on different edges; only a value seen on two
    // edges in a row is applied, so no word gets a half-changed coding
    fmt_prev_q <= fmt_s_q;
    if (fmt_s_q == fmt_prev_q)
    begin
      fmt_use_q <= fmt_s_q;
    end
  end

  // clamp out-of-range samples and raise the flag
  always_comb
  begin
    stage_in.oor = i_sample.over | i_sample.under;
    if (i_sample.over)
    begin
      stage_in.code = AOSC_CODE_POS_FS;
    end
    else if (i_sample.under)
    begin
      stage_in.code = AOSC_CODE_NEG_FS;
    end
    else
    begin
      stage_in.code = i_sample.code;
    end
  end

  // pipeline: flag travels with its code through every stage
  always_ff @(posedge i_sample_clk)
  begin
    pipe_q[0] <= stage_in;
    for (int i = 1; i < LATENCY - 1; i++)
    begin
      pipe_q[i] <= pipe_q[i-1];
    end
  end

  // coding of the word leaving the pipeline
  always_comb
  begin
    case (aosc_fmt_type'(fmt_use_q))
      AOSC_FMT_TWOS:
      begin
        // msb inverted relative to offset binary
        fmt_word = pipe_q[LATENCY-2].code ^ {1'b1, {(DATA_W-1){1'b0}}};
      end
      AOSC_FMT_GRAY:
      begin
        // binary-reflected gray of the offset binary result
        fmt_word = pipe_q[LATENCY-2].code
                   ^ (pipe_q[LATENCY-2].code >> 1);
      end
      default:
      begin
        fmt_word = pipe_q[LATENCY-2].code;
      end
    endcase
  end

  // output register: one new word per rising sample edge
  always_ff @(posedge i_sample_clk)
  begin
    if (!run_s_q)
    begin
      // converter stopped: outputs rest at zero
      data_q <= '0;
      oor_q <= 1'b0;
    end
    else
    begin
      data_q <= fmt_word;
      oor_q <= pipe_q[LATENCY-2].oor;
    end
  end

  assign o_data = data_q;
  assign o_out_of_range = oor_q;

  // data clock rises mid-word, half a period after launch
  assign o_data_clock_out = ~i_sample_clk & run_s_q;

endmodule

// [design/aosc_pkg.sv]
// aosc_pkg: shared constants and types for the converter output stage.
// assumes a 200 MHz core clock and a separate sample clock domain.
package aosc_pkg;

  // result word width and pipeline depth in sample-clock cycles
  localparam int AOSC_DATA_W = 14;
  localparam int AOSC_LATENCY = 12;

  // core clock period in nanoseconds
  localparam real AOSC_CLK_PERIOD_NS = 5.0;

  // reference discharge time and full wake-up time, in milliseconds
  localparam real AOSC_DISCH_TIME_MS = 0.25;
  localparam real AOSC_WAKE_TIME_MS = 0.35;
  // wake-up time after standby, in microseconds (reference stays up)
  localparam real AOSC_STBY_WAKE_TIME_US = 1.0;

  // cycle counts derived from the times above
  localparam int AOSC_DISCH_CYCLES =
    int'($floor(AOSC_DISCH_TIME_MS * 1.0e6 / AOSC_CLK_PERIOD_NS));
  localparam int AOSC_WAKE_CYCLES =
    int'($floor(AOSC_WAKE_TIME_MS * 1.0e6 / AOSC_CLK_PERIOD_NS));
  localparam int AOSC_STBY_WAKE_CYCLES =
    int'($floor(AOSC_STBY_WAKE_TIME_US * 1.0e3 / AOSC_CLK_PERIOD_NS));

  // counter width for the power timing counters
  localparam int AOSC_CNT_W = 24;

  // coded result levels in offset binary
  localparam logic [AOSC_DATA_W-1:0] AOSC_CODE_NEG_FS = 14'h0000;
  localparam logic [AOSC_DATA_W-1:0] AOSC_CODE_ZERO = 14'h2000;
  localparam logic [AOSC_DATA_W-1:0] AOSC_CODE_POS_FS = 14'h3fff;
  localparam int AOSC_MSB = AOSC_DATA_W - 1;

  // output coding choices
  typedef enum logic [1:0]
  {
    AOSC_FMT_BINARY = 2'h0,
    AOSC_FMT_TWOS = 2'h1,
    AOSC_FMT_GRAY = 2'h2
  } aosc_fmt_type;

  // one raw sample from the converter core
  typedef struct packed
  {
    logic [AOSC_DATA_W-1:0] code;
    logic over;
    logic under;
  } aosc_sample_type;

  // one pipeline entry: clamped code with its range flag
  typedef struct packed
  {
    logic [AOSC_DATA_W-1:0] code;
    logic oor;
  } aosc_stage_type;

endpackage

// [verif/aosc_capture_model.sv]
// aosc_capture_model: receiving register at the far side of the pins.
// assumes data and flag are valid at the data clock rising edge.
`timescale 1ns/100ps
module aosc_capture_model
  import aosc_pkg::*;
(
  input wire logic i_dco,
  input wire logic [AOSC_DATA_W-1:0] i_bus,
  input wire logic i_flag,
  output logic [AOSC_DATA_W-1:0] o_word,
  output logic o_flag,
  output logic [1:0] o_range
);
  // capture word and flag; classify range as {over, under}
  always_ff @(posedge i_dco)
  begin
    o_word <= i_bus;
    o_flag <= i_flag;
    o_range <= {i_flag & i_bus[AOSC_MSB], i_flag & ~i_bus[AOSC_MSB]};
  end
endmodule

// [verif/aosc_output_stage_monitor.sv]
// aosc_output_stage_monitor: port timing checks for the output stage.
// bound into aosc_output_stage; sees only its ports.
`timescale 1ns/100ps
module aosc_output_stage_monitor
  import aosc_pkg::*;
#(
  parameter int DATA_W = AOSC_DATA_W,
  parameter int LATENCY = AOSC_LATENCY
)
(
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  input wire logic i_power_down_pin,
  input wire logic i_output_enable_n,
  input wire logic i_serial_select_n,
  input wire logic i_serial_standby,
  input wire logic i_sample_clk,
  input wire aosc_sample_type i_sample,
  input wire logic [DATA_W-1:0] o_data,
  input wire logic o_data_oe,
  input wire logic o_out_of_range,
  input wire logic o_data_clock_out,
  input wire logic o_converting
);
  logic [4:0] run_q; // sample edges seen running
  logic [2:0] stop_q; // sample edges seen stopped
  // count sample edges in the running state
  always_ff @(posedge i_sample_clk)
  begin
    if (!o_converting)
      run_q <= 5'h00;
    else if (run_q != 5'h1f)
      run_q <= run_q + 5'h01;
  end
  // count sample edges in the stopped state
  always_ff @(posedge i_sample_clk)
  begin
    if (o_converting)
      stop_q <= 3'h0;
    else if (stop_q != 3'h7)
      stop_q <= stop_q + 3'h1;
  end
  a_flag_latency: assert property (
    @(posedge i_sample_clk) disable iff (!i_reset_n) run_q >= 5'h10
    |-> o_out_of_range == ($past(i_sample.over, LATENCY)
    | $past(i_sample.under, LATENCY)))
    else $error("range flag misaligned");
  a_under_clamp: assert property (
    @(posedge i_sample_clk) disable iff (!i_reset_n) run_q >= 5'h10
    && $past(i_sample.under, LATENCY) && !$past(i_sample.over, LATENCY)
    |-> o_data[DATA_W-2:0] == '0)
    else $error("underrange word not clamped");
  a_dco_runs: assert property (
    @(posedge i_sample_clk) disable iff (!i_reset_n)
    run_q >= 5'h10 |-> o_data_clock_out)
    else $error("data clock not toggling");
  a_dco_idle: assert property (
    @(posedge i_sample_clk) disable iff (!i_reset_n) stop_q >= 3'h5
    |-> !o_data_clock_out && o_data == '0 && !o_out_of_range)
    else $error("outputs active while stopped");
  a_launch_edge: assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    $changed(o_data) |-> i_sample_clk)
    else $error("word changed off the rising edge");
  a_pd_tristate: assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    i_power_down_pin [*5] |-> !o_data_oe && !o_converting)
    else $error("drivers on in power-down");
  a_oe_tristate: assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    i_output_enable_n [*5] |-> !o_data_oe)
    else $error("drivers on while disabled");
  a_oe_drive: assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (!i_power_down_pin && !i_output_enable_n && i_serial_select_n) [*5]
    |-> o_data_oe)
    else $error("drivers off while enabled");
  a_wake_hold: assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    i_power_down_pin [*5] ##1 !i_power_down_pin |=> !o_converting [*2])
    else $error("woke without delay");
  a_standby_off: assert property (
    @(posedge i_core_clk) disable iff (!i_reset_n)
    (!i_serial_select_n && i_serial_standby) [*5] |-> !o_data_oe)
    else $error("drivers on in standby");
  c_flag: cover property (@(posedge i_sample_clk) o_out_of_range);
  c_down: cover property (@(posedge i_core_clk) $fell(o_converting));
  c_wake: cover property (@(posedge i_core_clk) $rose(o_converting));
endmodule

// [verif/tb_aosc_output_stage.sv]
// tb_aosc_output_stage: drives the output stage and checks its pins.
// the capture model stands in for the receiving logic.
`timescale 1ns/100ps
module tb_aosc_output_stage;
  import aosc_pkg::*;
  logic clk = 1'b0;
  logic sclk = 1'b0;
  logic rst_n = 1'b0;
  logic pd = 1'b0;
  logic oe_n = 1'b0;
  logic fsel = 1'b0;
  logic ssel_n = 1'b1;
  logic stby = 1'b0;
  aosc_fmt_type sfmt = AOSC_FMT_BINARY;
  aosc_sample_type smp = '0;
  logic [13:0] dout;
  logic [13:0] cap;
  logic oe, oor, oor_oe, data_clock_out, conv, cflag;
  logic [1:0] crange;
  wire [13:0] bus = oe ? dout : 14'bz;
  wire flag = oor_oe ? oor : 1'bz;
  int bad_count = 0;
  int compares = 0;
  aosc_sample_type hist[$];
  aosc_sample_type tbl[8] = '{16'h0000, 16'h48d2, 16'h2af1, 16'hffff,
    16'h8000, 16'hfffc, 16'h5554, 16'h0005};
  always #2.5 clk = ~clk;
  // sample clock, 30 ns, offset from the core clock
  initial
  begin
    #1.3;
    forever #15 sclk = ~sclk;
  end
  aosc_output_stage #(
    .DISCH_CYCLES(20),
    .WAKE_CYCLES(28),
    .STBY_WAKE_CYCLES(4)
  ) dut (
    .i_core_clk(clk), .i_reset_n(rst_n), .i_core_ce(1'b1),
    .i_power_down_pin(pd), .i_output_enable_n(oe_n),
    .i_format_select_pin(fsel), .i_serial_select_n(ssel_n),
    .i_serial_format(sfmt), .i_serial_power_down(1'b0),
    .i_serial_standby(stby), .i_sample_clk(sclk), .i_sample(smp),
    .o_data(dout), .o_data_oe(oe), .o_out_of_range(oor),
    .o_out_of_range_oe(oor_oe), .o_data_clock_out(data_clock_out),
    .o_converting(conv)
  );
  aosc_capture_model rx (
    .i_dco(data_clock_out), .i_bus(bus), .i_flag(flag),
    .o_word(cap), .o_flag(cflag), .o_range(crange)
  );
  task automatic check(input logic [15:0] exp, input logic [15:0] seen,
    input string what);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // expected pin word for one raw sample in format f
  function automatic logic [13:0] fmt_word(aosc_sample_type s,
    logic [1:0] f);
    logic [13:0] ob;
    ob = s.over ? AOSC_CODE_POS_FS : (s.under ? AOSC_CODE_NEG_FS : s.code);
    if (f == 2'h1)
      return ob ^ AOSC_CODE_ZERO;
    if (f == 2'h2)
      return ob ^ (ob >> 1);
    return ob;
  endfunction
  // send n samples; check captures twelve edges later (z when off)
  task automatic stream(input int n, input logic [1:0] f, input bit on);
    aosc_sample_type s;
    hist.delete();
    repeat (4) @(posedge sclk);
    for (int i = 0; i < n; i++)
    begin
      @(negedge sclk);
      smp <= tbl[i % 8];
      hist.push_back(tbl[i % 8]);
      @(posedge sclk);
      if (hist.size() > 12)
      begin
        s = hist.pop_front();
        check(on ? fmt_word(s, f) : 14'bz, cap, "word");
        check(on ? s.over | s.under : 1'bz, cflag, "flag");
        if (on && f == 2'h0)
          check({s.over, s.under & ~s.over}, crange, "range");
      end
    end
  endtask
  // bounded wait for the run state to return
  task automatic wait_conv(input int lim);
    int n;
    n = 0;
    while (conv !== 1'b1 && n < lim)
    begin
      cyc(1);
      n++;
    end
    check(1'b1, conv, "wake");
    if (conv !== 1'b1)
      complete_run();
  endtask
  initial
  begin
    cyc(6);
    rst_n = 1'b1;
    cyc(4);
    for (int c = 0; c < 6; c++)
    begin
      cyc(1);
      ssel_n = c < 2;
      fsel = c[0];
      sfmt = c < 2 ? AOSC_FMT_GRAY : aosc_fmt_type'(c - 2);
      stream(28, c < 2 ? 2'(c) : (c == 5 ? 2'h0 : 2'(c - 2)), 1'b1);
    end
    cyc(1);
    pd = 1'b1;
    cyc(60);
    check(1'b0, oe, "oe");
    check(1'b0, conv, "run");
    pd = 1'b0;
    cyc(22);
    check(1'b0, conv, "run");
    wait_conv(20);
    pd = 1'b1;
    cyc(8);
    pd = 1'b0;
    wait_conv(16);
    stby = 1'b1;
    cyc(10);
    check(1'b0, oe, "oe");
    cyc(40);
    stby = 1'b0;
    wait_conv(12);
    ssel_n = 1'b1;
    stby = 1'b1;
    cyc(10);
    check(1'b1, conv, "run");
    stby = 1'b0;
    oe_n = 1'b1;
    cyc(5);
    check(1'b0, oe, "oe");
    stream(20, 2'h0, 1'b0);
    cyc(1);
    oe_n = 1'b0;
    fsel = 1'b0;
    stream(20, 2'h0, 1'b1);
    complete_run();
  end
endmodule
bind aosc_output_stage aosc_output_stage_monitor #(
  .DATA_W(DATA_W),
  .LATENCY(LATENCY)
) mon (.*);
